// file: src/dcac_pkg.sv
package dcac_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int DCAC_NCH = 8;
  localparam int DCAC_CNT_W = 16;
  localparam int DCAC_ADDR_W = 9;
  localparam int DCAC_DATA_W = 32;
  localparam int DCAC_RATIO_W = 8;
  localparam int DCAC_WAIT_W = 8;
  localparam int DCAC_CTL_W = 16;
  localparam int DCAC_STS_W = 4;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [DCAC_ADDR_W-1:0] DCAC_OFS_RATIO = 9'h000;
  localparam logic [DCAC_ADDR_W-1:0] DCAC_OFS_BSTAT = 9'h004;
  // per channel window: 0x20 bytes each, channel 0 at 0x020
  localparam int DCAC_WIN_LSB = 5;
  localparam logic [3:0] DCAC_WIN_FIRST = 4'h1;
  localparam logic [4:0] DCAC_ROFS_CTRL = 5'h00;
  localparam logic [4:0] DCAC_ROFS_STS = 5'h04;
  localparam logic [4:0] DCAC_ROFS_CNTA = 5'h10;
  localparam logic [4:0] DCAC_ROFS_CNTB = 5'h1C;

  // ****************************************************************
  // channel control fields
  // ****************************************************************
  localparam int DCAC_CTL_RST = 0;
  localparam int DCAC_CTL_PAUSE = 1;
  localparam int DCAC_CTL_HIPRI = 2;
  localparam int DCAC_CTL_IRQEN = 3;
  localparam int DCAC_CTL_M2M = 4;
  localparam int DCAC_CTL_WAIT_LSB = 8;

  // ****************************************************************
  // channel status fields
  // ****************************************************************
  localparam int DCAC_STS_BUFB = 0;
  localparam int DCAC_STS_WAIT = 1;
  localparam int DCAC_STS_REQ = 2;
  localparam int DCAC_STS_GRANT = 3;

  localparam logic [DCAC_RATIO_W-1:0] DCAC_RATIO_ONE = 8'h01;
  localparam logic [DCAC_RATIO_W-1:0] DCAC_RATIO_ZERO = 8'h00;

  typedef enum logic {DCAC_ST_IDLE, DCAC_ST_BUSY} dcac_state_t;

endpackage

// file: src/dcac_dma_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - each channel holds an 8-bit wait count in system clocks after each transfer
// - wait follows reads and writes alike; ready ignored until it expires
// - memory-to-memory channel starts once either buffer count is nonzero
// - pause set when a count is written holds the transfer until cleared
// - all channels equal priority by default; each may be made high priority
// - ratio sets high grants per low grant while both classes request
// - ratio field holds only 0,1,3,7,15,31,63,127,255
// - internal ratio counter loaded from ratio; low allowed over a high request only at zero
// - each high grant decrements a nonzero ratio counter by one
// - each low grant reloads the counter from the ratio field
// - ratio zero rotates high and low round robin
// - ratio one alternates strictly between high and low
// - all logic runs on the single system clock
// - every register is zero after power-up
// - external soft reset bit holds the whole engine reset while one
// - writing one to a channel reset bit resets only that channel
// - exactly one combined interrupt output
// - a channel adds to the interrupt only with its enable set
// - buffer status shows which buffer of which channel completed
// - pause stalls new requests of its channel until software clears it
// - first count write to an empty channel starts on that buffer; the other follows when it empties
// - ratio register at offset 0x000, buffer status at 0x004, both zero at reset
module dcac_dma_ctrl
  import dcac_pkg::*;
#(
  parameter int NCH = DCAC_NCH,
  parameter int CNT_W = DCAC_CNT_W
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic soft_rst_hold,
  // register port
  input wire logic [DCAC_ADDR_W-1:0] reg_addr,
  input wire logic [DCAC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DCAC_DATA_W-1:0] reg_rdata,
  // peripherals and data mover
  input wire logic [NCH-1:0] periph_ready,
  input wire logic xfer_done,
  output logic grant_valid,
  output logic [$clog2(NCH)-1:0] grant_ch,
  output logic grant_buf,
  // interrupt
  output logic dma_irq
);

  localparam int CH_W = $clog2(NCH);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    dcac_state_t st;
    logic [DCAC_RATIO_W-1:0] ratio;
    logic [DCAC_RATIO_W-1:0] ratio_cnt;
    logic last_hi;
    logic [CH_W-1:0] rr_hi;
    logic [CH_W-1:0] rr_lo;
    logic gvalid;
    logic [CH_W-1:0] g_ch;
    logic g_buf;
    logic [NCH-1:0][DCAC_CTL_W-1:0] ctrl;
    logic [NCH-1:0][CNT_W-1:0] cnt_a;
    logic [NCH-1:0][CNT_W-1:0] cnt_b;
    logic [NCH-1:0] sel_b;
    logic [NCH-1:0][DCAC_WAIT_W-1:0] wait_cnt;
    logic [2*NCH-1:0] bstat;
    logic [NCH-1:0] s1;
    logic [NCH-1:0] s2;
    logic [NCH-1:0] s3;
    logic [NCH-1:0] rdy_f;
    logic irq;
    logic [DCAC_DATA_W-1:0] rdata;
  } dcac_regs_t;

  dcac_regs_t q;
  dcac_regs_t d;

  assign reg_rdata = q.rdata;
  assign grant_valid = q.gvalid;
  assign grant_ch = q.g_ch;
  assign grant_buf = q.g_buf;
  assign dma_irq = q.irq;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // rotation assumes NCH is a power of two so the index wraps for free
  function automatic logic [CH_W:0] rr_pick(input logic [NCH-1:0] req,
                                            input logic [CH_W-1:0] last);
    logic [CH_W:0] res;
    logic [CH_W-1:0] idx;
    res = '0;
    for (int i = NCH; i >= 1; i--) begin
      idx = last + CH_W'(i);
      if (req[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  function automatic logic ratio_ok(input logic [DCAC_RATIO_W-1:0] v);
    return (v & (v + DCAC_RATIO_ONE)) == DCAC_RATIO_ZERO;
  endfunction

  // ****************************************************************
  // per channel request
  // ****************************************************************
  logic [NCH-1:0] use_b;
  logic [NCH-1:0] cur_nz;
  logic [NCH-1:0] req;
  logic [NCH-1:0] hipri;
  logic [NCH-1:0] irq_src;

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    // selected buffer first; switch to the other only when the selected one is empty
    assign use_b[c] = q.sel_b[c] ? (q.cnt_b[c] != '0 || q.cnt_a[c] == '0)
                                 : (q.cnt_a[c] == '0);
    assign cur_nz[c] = use_b[c] ? (q.cnt_b[c] != '0) : (q.cnt_a[c] != '0);
    // stale ready is ignored while the wait count runs down
    assign req[c] = cur_nz[c] && !q.ctrl[c][DCAC_CTL_PAUSE] && q.wait_cnt[c] == '0
                    && (q.ctrl[c][DCAC_CTL_M2M] || q.rdy_f[c]);
    assign hipri[c] = q.ctrl[c][DCAC_CTL_HIPRI];
    assign irq_src[c] = q.ctrl[c][DCAC_CTL_IRQEN] && (|q.bstat[2*c +: 2]);
  end

  // ****************************************************************
  // arbiter decision
  // ****************************************************************
  logic [NCH-1:0] hi_req;
  logic [NCH-1:0] lo_req;
  logic [CH_W:0] hp;
  logic [CH_W:0] lp;
  logic lo_ok;
  logic pick_hi;
  logic [CH_W-1:0] pick_ch;
  logic go;

  assign hi_req = req & hipri;
  assign lo_req = req & ~hipri;
  assign hp = rr_pick(hi_req, q.rr_hi);
  assign lp = rr_pick(lo_req, q.rr_lo);
  // ratio zero: counter stays zero, so the last_hi flag forces the alternation
  assign lo_ok = q.ratio_cnt == DCAC_RATIO_ZERO
                 && (q.ratio != DCAC_RATIO_ZERO || q.last_hi);
  assign pick_hi = (|hi_req) && !((|lo_req) && lo_ok);
  assign pick_ch = pick_hi ? hp[CH_W-1:0] : lp[CH_W-1:0];
  assign go = q.st == DCAC_ST_IDLE && (|req);

  // ****************************************************************
  // register decode
  // ****************************************************************
  logic [DCAC_ADDR_W-DCAC_WIN_LSB-1:0] wsel;
  logic win_hit;
  logic [CH_W-1:0] wch;
  logic [DCAC_WIN_LSB-1:0] roff;
  logic chrst;
  logic abort;
  logic [DCAC_STS_W-1:0] sts;

  assign wsel = reg_addr[DCAC_ADDR_W-1:DCAC_WIN_LSB];
  assign win_hit = wsel >= DCAC_WIN_FIRST && wsel < DCAC_WIN_FIRST + 4'(NCH);
  assign wch = CH_W'(wsel - DCAC_WIN_FIRST);
  assign roff = reg_addr[DCAC_WIN_LSB-1:0];
  assign chrst = reg_wr && win_hit && roff == DCAC_ROFS_CTRL && reg_wdata[DCAC_CTL_RST];
  assign abort = chrst && q.gvalid && q.g_ch == wch;

  always_comb begin
    sts = '0;
    sts[DCAC_STS_BUFB] = use_b[wch];
    sts[DCAC_STS_WAIT] = q.wait_cnt[wch] != '0;
    sts[DCAC_STS_REQ] = req[wch];
    sts[DCAC_STS_GRANT] = q.gvalid && q.g_ch == wch;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    // three stage pin sync; a change counts once stages two and three agree
    d.s1 = periph_ready;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.rdy_f = (q.s2 & q.s3) | (q.rdy_f & (q.s2 ^ q.s3));
    d.rdata = '0;
    for (int c = 0; c < NCH; c++) begin
      if (q.wait_cnt[c] != '0) begin
        d.wait_cnt[c] = q.wait_cnt[c] - 1'b1;
      end
    end
    // software writes
    if (reg_wr) begin
      if (reg_addr == DCAC_OFS_RATIO) begin
        // reserved encodings are dropped; the field keeps its old value
        if (ratio_ok(reg_wdata[DCAC_RATIO_W-1:0])) begin
          d.ratio = reg_wdata[DCAC_RATIO_W-1:0];
          // restart the count so a stale count from the old ratio cannot starve low
          d.ratio_cnt = reg_wdata[DCAC_RATIO_W-1:0];
        end
      end else if (reg_addr == DCAC_OFS_BSTAT) begin
        d.bstat = q.bstat & ~reg_wdata[2*NCH-1:0];
      end else if (win_hit) begin
        if (roff == DCAC_ROFS_CTRL) begin
          d.ctrl[wch] = reg_wdata[DCAC_CTL_W-1:0];
          d.ctrl[wch][DCAC_CTL_RST] = 1'b0;
          if (reg_wdata[DCAC_CTL_RST]) begin
            d.ctrl[wch] = '0;
            d.cnt_a[wch] = '0;
            d.cnt_b[wch] = '0;
            d.sel_b[wch] = 1'b0;
            d.wait_cnt[wch] = '0;
            d.bstat[2*wch +: 2] = 2'h0;
          end
        end else if (roff == DCAC_ROFS_CNTA) begin
          d.cnt_a[wch] = reg_wdata[CNT_W-1:0];
          if (q.cnt_a[wch] == '0 && q.cnt_b[wch] == '0) begin
            d.sel_b[wch] = 1'b0;
          end
        end else if (roff == DCAC_ROFS_CNTB) begin
          d.cnt_b[wch] = reg_wdata[CNT_W-1:0];
          if (q.cnt_a[wch] == '0 && q.cnt_b[wch] == '0) begin
            d.sel_b[wch] = 1'b1;
          end
        end
      end
    end
    // software reads, data in the following cycle only
    if (reg_rd) begin
      if (reg_addr == DCAC_OFS_RATIO) begin
        d.rdata = DCAC_DATA_W'(q.ratio);
      end else if (reg_addr == DCAC_OFS_BSTAT) begin
        d.rdata = DCAC_DATA_W'(q.bstat);
      end else if (win_hit && roff == DCAC_ROFS_CTRL) begin
        d.rdata = DCAC_DATA_W'(q.ctrl[wch]);
      end else if (win_hit && roff == DCAC_ROFS_STS) begin
        d.rdata = DCAC_DATA_W'(sts);
      end else if (win_hit && roff == DCAC_ROFS_CNTA) begin
        d.rdata = DCAC_DATA_W'(q.cnt_a[wch]);
      end else if (win_hit && roff == DCAC_ROFS_CNTB) begin
        d.rdata = DCAC_DATA_W'(q.cnt_b[wch]);
      end
    end
    // grant and completion; placed after the writes so a completion beats a clear
    case (q.st)
      DCAC_ST_IDLE: begin
        if (go) begin
          d.st = DCAC_ST_BUSY;
          d.gvalid = 1'b1;
          d.g_ch = pick_ch;
          d.g_buf = use_b[pick_ch];
          d.sel_b[pick_ch] = use_b[pick_ch];
          d.last_hi = pick_hi;
          if (pick_hi) begin
            d.rr_hi = pick_ch;
            if (q.ratio_cnt != DCAC_RATIO_ZERO) begin
              d.ratio_cnt = q.ratio_cnt - DCAC_RATIO_ONE;
            end
          end else begin
            d.rr_lo = pick_ch;
            d.ratio_cnt = q.ratio;
          end
        end
      end
      DCAC_ST_BUSY: begin
        if (abort) begin
          d.st = DCAC_ST_IDLE;
          d.gvalid = 1'b0;
        end else if (xfer_done) begin
          d.st = DCAC_ST_IDLE;
          d.gvalid = 1'b0;
          // wait applies after every cycle, read or write
          d.wait_cnt[q.g_ch] = q.ctrl[q.g_ch][DCAC_CTL_WAIT_LSB +: DCAC_WAIT_W];
          if (q.g_buf) begin
            if (q.cnt_b[q.g_ch] != '0) begin
              d.cnt_b[q.g_ch] = q.cnt_b[q.g_ch] - 1'b1;
            end
            if (q.cnt_b[q.g_ch] == CNT_W'(1)) begin
              d.bstat[2*q.g_ch + 1] = 1'b1;
              d.sel_b[q.g_ch] = 1'b0;
            end
          end else begin
            if (q.cnt_a[q.g_ch] != '0) begin
              d.cnt_a[q.g_ch] = q.cnt_a[q.g_ch] - 1'b1;
            end
            if (q.cnt_a[q.g_ch] == CNT_W'(1)) begin
              d.bstat[2*q.g_ch] = 1'b1;
              d.sel_b[q.g_ch] = 1'b1;
            end
          end
        end
      end
      default: begin
        d.st = DCAC_ST_IDLE;
      end
    endcase
    d.irq = |irq_src;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // one clock for everything; soft reset hold acts like the pin reset
  always_ff @(posedge sys_clk) begin
    if (!nrst || soft_rst_hold) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst || soft_rst_hold);

  ratio_legal_a: assert property (ratio_ok(q.ratio))
    else $error("ratio field holds a reserved value");

  lo_gate_a: assert property (go && !pick_hi && (|hi_req) |-> q.ratio_cnt == '0)
    else $error("low grant while ratio counter nonzero");

  hi_dec_a: assert property (go && pick_hi && q.ratio_cnt != '0
                            |=> q.ratio_cnt == $past(q.ratio_cnt) - 8'h01)
    else $error("high grant did not decrement ratio counter");

  lo_reload_a: assert property (go && !pick_hi |=> q.ratio_cnt == $past(q.ratio))
    else $error("low grant did not reload ratio counter");

  lo_free_a: assert property (q.st == DCAC_ST_IDLE && (|lo_req) && !(|hi_req)
                             |=> q.gvalid && !hipri[q.g_ch])
    else $error("lone low request not granted");

  wait_hold_a: assert property (q.gvalid && xfer_done && !abort
                               && q.ctrl[q.g_ch][DCAC_CTL_WAIT_LSB +: DCAC_WAIT_W] > 8'h01
                               |=> !(go && pick_ch == $past(q.g_ch)))
    else $error("channel regranted inside its wait time");

  pause_hold_a: assert property (go |-> !q.ctrl[pick_ch][DCAC_CTL_PAUSE])
    else $error("paused channel granted");

  irq_mask_a: assert property ((irq_src == '0) |=> !dma_irq)
    else $error("interrupt raised with no enabled source");

  alt_one_a: assert property (go && !reg_wr && (|hi_req) && (|lo_req) && q.ratio == 8'h01
                             && q.ratio_cnt == 8'h01 |=> q.gvalid && hipri[q.g_ch])
    else $error("ratio one did not alternate");

  rr_zero_a: assert property (go && !reg_wr && (|hi_req) && (|lo_req) && q.ratio == 8'h00
                             |=> q.gvalid && (hipri[q.g_ch] != $past(q.last_hi)))
    else $error("ratio zero did not rotate high and low");

  chan_rst_a: assert property (chrst |=> q.cnt_a[$past(wch)] == '0
                              && q.cnt_b[$past(wch)] == '0)
    else $error("channel reset left a count");

  ratio_load_a: assert property (reg_wr && reg_addr == DCAC_OFS_RATIO && !go
                                && ratio_ok(reg_wdata[DCAC_RATIO_W-1:0])
                                |=> q.ratio_cnt == $past(reg_wdata[DCAC_RATIO_W-1:0]))
    else $error("ratio write did not load the ratio counter");

  irq_set_a: assert property ((|irq_src) |=> dma_irq)
    else $error("enabled source did not raise the interrupt");

  bstat_set_a: assert property (q.gvalid && xfer_done && !abort && q.g_buf
                               && q.cnt_b[q.g_ch] == CNT_W'(1)
                               |=> q.bstat[2*$past(q.g_ch) + 1])
    else $error("drained buffer not flagged in buffer status");

endmodule // dcac_dma_ctrl

// file: testbench/dcac_mover_model.sv
`timescale 1ns/1ps
module dcac_mover_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // grant side of the engine
  input wire logic grant_valid,
  output logic xfer_done,
  // bench controls: cycles to finish a transfer, peripheral ready levels
  input wire logic [3:0] lat,
  input wire logic [7:0] ready_lvl,
  output logic [7:0] periph_ready
);
  logic [4:0] cnt_q;
  logic done_q;

  // peripherals hold their ready level as the bench sets it
  assign periph_ready = ready_lvl;
  assign xfer_done = done_q;

  // one done pulse per grant, lat cycles after it is seen; never a second one
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cnt_q <= 5'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!grant_valid) begin
        cnt_q <= 5'h00;
      end else if (cnt_q <= {1'b0, lat}) begin
        cnt_q <= cnt_q + 5'h01;
        done_q <= (cnt_q == {1'b0, lat});
      end
    end
  end
endmodule // dcac_mover_model

// file: testbench/dma_channel_arbiter_control_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module dma_channel_arbiter_control_tb;
  import dcac_pkg::*;
  localparam logic [31:0] M2M = 32'h1 << DCAC_CTL_M2M;
  localparam logic [31:0] PAU = 32'h1 << DCAC_CTL_PAUSE;
  localparam logic [31:0] HIP = 32'h1 << DCAC_CTL_HIPRI;
  localparam logic [31:0] IEN = 32'h1 << DCAC_CTL_IRQEN;
  logic sys_clk = 1'b0, nrst = 1'b0, soft_rst_hold = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0] ready_lvl = 8'h00, periph_ready;
  logic [3:0] lat = 4'h0;
  logic xfer_done, grant_valid, grant_buf, dma_irq, gv_q = 1'b0;
  logic [2:0] grant_ch;
  int fails = 0, total_checks = 0, cyc = 0;
  logic [2:0] gq[$];
  logic gb[$];
  int gt[$], gf[$];

  always #25 sys_clk = ~sys_clk;

  dcac_dma_ctrl i_dut (.sys_clk(sys_clk), .nrst(nrst), .soft_rst_hold(soft_rst_hold),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .periph_ready(periph_ready), .xfer_done(xfer_done),
    .grant_valid(grant_valid), .grant_ch(grant_ch), .grant_buf(grant_buf), .dma_irq(dma_irq));
  dcac_mover_model i_mover (.sys_clk(sys_clk), .nrst(nrst), .grant_valid(grant_valid),
    .xfer_done(xfer_done), .lat(lat), .ready_lvl(ready_lvl), .periph_ready(periph_ready));

  // ****************************************************************
  // grant log: channel, buffer, rise and fall cycle
  // ****************************************************************
  always @(posedge sys_clk) begin
    cyc++;
    gv_q <= grant_valid;
    if (grant_valid && !gv_q) begin
      gq.push_back(grant_ch);
      gb.push_back(grant_buf);
      gt.push_back(cyc);
    end
    if (!grant_valid && gv_q) gf.push_back(cyc);
  end

  // ****************************************************************
  // bus and helper tasks
  // ****************************************************************
  function automatic logic [8:0] ca(input int ch, input logic [4:0] o);
    return 9'(32'h20 + ch * 32 + int'(o));
  endfunction
  task wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge sys_clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk); reg_wr <= 1'b0;
  endtask
  task rdchk(input logic [8:0] a, input logic [31:0] e);
    @(posedge sys_clk); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk); reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task cw(input int n); repeat (n) @(posedge sys_clk); endtask
  task grants(input int n);
    int k;
    k = 0;
    while (gq.size() < n && k < 400) begin @(posedge sys_clk); k++; end
    `CHK(gq.size() >= n, 1'b1)
  endtask
  task clr; gq.delete(); gb.delete(); gt.delete(); gf.delete(); endtask
  // channel reset plus drained-buffer flags cleared, so tests stay independent
  task quiet(input int ch); wr(ca(ch, DCAC_ROFS_CTRL), 32'h1); wr(DCAC_OFS_BSTAT, 32'hFFFF); endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    `CHK(dma_irq, 1'b0)
    rdchk(DCAC_OFS_RATIO, 32'h0);
    rdchk(DCAC_OFS_BSTAT, 32'h0);
    for (int c = 0; c < 8; c++) begin
      rdchk(ca(c, DCAC_ROFS_CTRL), 32'h0);
      rdchk(ca(c, DCAC_ROFS_CNTB), 32'h0);
    end
    rdchk(9'h008, 32'h0);
  endtask
  task t_ratio;
    logic [7:0] ok[9];
    ok = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h7F, 8'hFF};
    foreach (ok[i]) begin
      wr(DCAC_OFS_RATIO, {24'h0, ok[i]});
      rdchk(DCAC_OFS_RATIO, {24'h0, ok[i]});
    end
    wr(DCAC_OFS_RATIO, 32'h2);
    rdchk(DCAC_OFS_RATIO, 32'hFF);
    wr(DCAC_OFS_RATIO, 32'h80);
    rdchk(DCAC_OFS_RATIO, 32'hFF);
  endtask
  task t_irq;
    wr(ca(0, DCAC_ROFS_CTRL), M2M | IEN);
    clr();
    wr(ca(0, DCAC_ROFS_CNTA), 32'h1);
    wr(ca(0, DCAC_ROFS_CNTB), 32'h1);
    grants(2);
    `CHK(gq[0], 3'd0)
    `CHK(gb[0], 1'b0)
    `CHK(gb[1], 1'b1)
    cw(3);
    rdchk(DCAC_OFS_BSTAT, 32'h3);
    `CHK(dma_irq, 1'b1)
    wr(DCAC_OFS_BSTAT, 32'h1);
    rdchk(DCAC_OFS_BSTAT, 32'h2);
    `CHK(dma_irq, 1'b1)
    wr(DCAC_OFS_BSTAT, 32'h2);
    cw(2);
    `CHK(dma_irq, 1'b0)
    quiet(0);
  endtask
  task t_pause;
    wr(ca(6, DCAC_ROFS_CTRL), M2M | PAU);
    clr();
    wr(ca(6, DCAC_ROFS_CNTA), 32'h1);
    cw(20);
    `CHK(gq.size(), 0)
    rdchk(ca(6, DCAC_ROFS_STS), 32'h0);
    wr(ca(6, DCAC_ROFS_CTRL), M2M);
    grants(1);
    `CHK(gq[0], 3'd6)
    cw(4);
    rdchk(DCAC_OFS_BSTAT, 32'h1000);
    `CHK(dma_irq, 1'b0)
    quiet(6);
  endtask
  task t_wait;
    lat <= 4'h2;
    wr(ca(5, DCAC_ROFS_CTRL), M2M | 32'h0500);
    clr();
    wr(ca(5, DCAC_ROFS_CNTA), 32'h2);
    grants(2);
    `CHK((gt[1] - gf[0]) inside {[5:7]}, 1'b1)
    cw(6);
    quiet(5);
    lat <= 4'h0;
  endtask
  task t_ready;
    wr(ca(4, DCAC_ROFS_CTRL), 32'h0);
    clr();
    wr(ca(4, DCAC_ROFS_CNTA), 32'h1);
    cw(12);
    `CHK(gq.size(), 0)
    ready_lvl <= 8'h10;
    grants(1);
    `CHK(gq[0], 3'd4)
    ready_lvl <= 8'h00;
    cw(6);
    quiet(4);
  endtask
  task t_arb(input logic [7:0] r);
    int i, n;
    wr(DCAC_OFS_RATIO, {24'h0, r});
    wr(ca(0, DCAC_ROFS_CTRL), M2M | HIP);
    wr(ca(1, DCAC_ROFS_CTRL), M2M);
    clr();
    wr(ca(0, DCAC_ROFS_CNTA), 32'h10);
    wr(ca(1, DCAC_ROFS_CNTA), 32'h10);
    grants(12);
    i = -1;
    n = (r == 8'h00) ? 1 : int'(r);
    foreach (gq[k]) if (i < 0 && gq[k] == 3'd1) i = k;
    `CHK(i inside {[0:4]}, 1'b1)
    if (i >= 0 && i <= 4) begin
      for (int k = 1; k <= n; k++) `CHK(gq[i + k], 3'd0)
      `CHK(gq[i + n + 1], 3'd1)
    end
    quiet(0);
    quiet(1);
  endtask
  task t_rr;
    wr(ca(2, DCAC_ROFS_CTRL), M2M);
    wr(ca(3, DCAC_ROFS_CTRL), M2M);
    clr();
    wr(ca(2, DCAC_ROFS_CNTA), 32'h4);
    wr(ca(3, DCAC_ROFS_CNTB), 32'h4);
    grants(5);
    for (int k = 2; k < 5; k++) `CHK(gq[k] != gq[k - 1], 1'b1)
    `CHK(gb[1], 1'b1)
    quiet(2);
    quiet(3);
  endtask
  task t_chrst;
    wr(ca(0, DCAC_ROFS_CTRL), M2M | PAU);
    wr(ca(1, DCAC_ROFS_CTRL), M2M | PAU);
    wr(ca(0, DCAC_ROFS_CNTA), 32'h5);
    wr(ca(1, DCAC_ROFS_CNTA), 32'h5);
    wr(ca(0, DCAC_ROFS_CTRL), M2M | PAU | 32'h1);
    rdchk(ca(0, DCAC_ROFS_CTRL), 32'h0);
    rdchk(ca(0, DCAC_ROFS_CNTA), 32'h0);
    rdchk(ca(1, DCAC_ROFS_CNTA), 32'h5);
    rdchk(ca(1, DCAC_ROFS_CTRL), M2M | PAU);
    quiet(1);
  endtask
  task t_soft;
    wr(DCAC_OFS_RATIO, 32'h7);
    @(posedge sys_clk); soft_rst_hold <= 1'b1;
    cw(2);
    soft_rst_hold <= 1'b0;
    rdchk(DCAC_OFS_RATIO, 32'h0);
    wr(DCAC_OFS_RATIO, 32'h1);
    rdchk(DCAC_OFS_RATIO, 32'h1);
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task conclude;
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // well under 1000 cycles of tests; 30000 cycles means a hang
  initial begin
    #(30000 * 50);
    fails++;
    conclude();
  end

  initial begin
    cw(6);
    nrst <= 1'b1;
    t_reset();
    t_ratio();
    t_irq();
    t_pause();
    t_wait();
    t_ready();
    t_arb(8'h00);
    t_arb(8'h01);
    t_arb(8'h03);
    t_rr();
    t_chrst();
    t_soft();
    conclude();
  end
endmodule // dma_channel_arbiter_control_tb
